// file: pkg/serial_port_consts.vh
// Constants for the serial port and mode latch block
// Summary of operation
// - Eleven volatile mode latches in two groups, written by serial commands.
// - Latches clear on power-on reset, survive a remote reset request.
// - Command bit 7 is data; low seven bits address a latch.
// - All-ones address is precharge; advances the record group pointer.
// - Read disable clear selects OTP configuration, set selects shadow.
// - Boost drive set turns motor outputs into charge-pump drive.
// - Write enable clear updates shadow only; set updates shadow and OTP.
// - In standalone mode with select high the latch request bit latches results.
// - Test lockout allows only precharge and group A writes.
// - Read transfers are staged through a 32-bit transmission latch bank.
// - Select, strobe and clock all high means idle, no serial transfer.
// - Select low enables communication; raising it aborts the task.
// - Standalone with select high drives meter status on port pins.
// - With select low, strobe high means read, low means write.
// - Select, strobe and clock high load results into transmission latches, outside standalone mode.
// - Active clock edge polarity follows the clock polarity bit.
// - Data pin outputs in read, inputs in write, idle input outside standalone mode.
// - Every port pin has a weak pull-up; undriven reads high.
// - Data changes on trailing clock edge, sampled on leading edge.
// - Write command is one byte: data bit then 7-bit address.
// - Clock of the last command bit queues the byte in the FIFO; the FIFO output strobes the latch write.
// - A read shifts 32 clocks per record, up to 8 records.
// - Bits of each read byte go msb first unless the bit order bit selects lsb first.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
`define ADDR_GROUP_A_BASE 7'h70
`define ADDR_GROUP_A_LAST 7'h73
`define ADDR_GROUP_B_BASE 7'h78
`define ADDR_GROUP_B_LAST 7'h7e
`define ADDR_PRECHARGE 7'h7f
`define CFG_ADDR_LIMIT 7'h70
`define CFG_ADDR_LOCKOUT 7'h00
`define CFG_ADDR_CLK_POL 7'h01
`define CFG_ADDR_BIT_ORDER 7'h02
`define CFG_ADDR_STANDALONE 7'h03
`define A_BIT_LATCH_REQ 0
`define B_BIT_BOOST 1
`define B_BIT_RD_DISABLE 5
`define B_BIT_WR_ENABLE 6
`define CMD_DATA_BIT 7
`define REC_BITS 32
`define REC_MAX 8
`define GROUP_PTR_W 3
`define FIFO_DEPTH 8
`define FIFO_WIDTH 8
`define RESET_MODE_A 4'h0
`define RESET_MODE_B 7'h00
`define RESET_CFG 112'h0
`define PUMP_DIV 6'h27
`endif

// file: logic/word_fifo.v
`timescale 1ns/100ps
// Small synchronous FIFO with valid/ready on both sides
module word_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;

    assign in_ready = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // word_fifo

// file: logic/meter_serial_port.v
`timescale 1ns/100ps
// Four-wire serial port with mode latches and transmission latches
`include "serial_port_consts.vh"
module meter_serial_port (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Serial port pins (pull-ups sit in the pad)
    input wire serial_chip_select,
    input wire direction_latch_strobe_in,
    output reg direction_latch_strobe_out,
    output reg direction_latch_strobe_oe,
    input wire serial_bit_clock_in,
    output reg serial_bit_clock_out,
    output reg serial_bit_clock_oe,
    input wire serial_data_line_in,
    output reg serial_data_line_out,
    output reg serial_data_line_oe,
    // Measurement side: result record and meter status
    input wire [31:0] result_record,
    input wire [2:0] meter_status,
    output reg [2:0] record_index,
    output reg [2:0] group_pointer,
    // Configuration side
    input wire [111:0] otp_cells,
    output reg [111:0] active_cfg,
    output reg otp_write_pulse,
    output reg [6:0] otp_write_addr,
    output reg otp_write_data,
    // Mode latch outputs
    output reg [3:0] mode_group_a,
    output reg [6:0] mode_group_b,
    output reg motor_out_pos,
    output reg motor_out_neg,
    // Motor drive from the pulse logic
    input wire motor_drive_pos,
    input wire motor_drive_neg
);
    localparam ST_IDLE = 2'b00;
    localparam ST_WRITE = 2'b01;
    localparam ST_READ = 2'b10;

    function in_range;
        input [6:0] a;
        input [6:0] lo;
        input [6:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // Three-stage pin samplers; stage 1 feeds only stage 2
    reg [2:0] cs_s1_ff, cs_s2_ff, cs_s3_ff;
    reg [2:0] pin_q;
    wire [2:0] pin_raw;
    reg data_s1_ff, data_s2_ff, data_s3_ff, data_q_ff;
    assign pin_raw = {serial_bit_clock_in, direction_latch_strobe_in,
        serial_chip_select};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cs_s1_ff[g] <= 1'b1;
                    cs_s2_ff[g] <= 1'b1;
                    cs_s3_ff[g] <= 1'b1;
                    pin_q[g] <= 1'b1;
                end else begin
                    cs_s1_ff[g] <= pin_raw[g];
                    cs_s2_ff[g] <= cs_s1_ff[g];
                    cs_s3_ff[g] <= cs_s2_ff[g];
                    if (cs_s2_ff[g] == cs_s3_ff[g]) begin
                        pin_q[g] <= cs_s3_ff[g];
                    end
                end
            end
        end
    endgenerate

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_s1_ff <= 1'b1;
            data_s2_ff <= 1'b1;
            data_s3_ff <= 1'b1;
            data_q_ff <= 1'b1;
        end else begin
            data_s1_ff <= serial_data_line_in;
            data_s2_ff <= data_s1_ff;
            data_s3_ff <= data_s2_ff;
            // Data takes the same path length as the clock pin
            if (data_s2_ff == data_s3_ff) begin
                data_q_ff <= data_s3_ff;
            end
        end
    end

    wire cs_n = pin_q[0];
    wire strobe = pin_q[1];
    reg clk_prev_ff;
    reg [1:0] state_ff;
    reg [111:0] shadow_ff;
    reg [7:0] cmd_ff;
    reg [2:0] bit_cnt_ff;
    reg [4:0] rec_bit_ff;
    reg [31:0] tx_latch_ff;
    reg [1:0] byte_cnt_ff;
    reg [7:0] cur_byte_ff;
    reg pump_phase_ff;
    reg [5:0] pump_cnt_ff;
    reg strobe_prev_ff;

    // Clock polarity follows the configuration
    wire pol = active_cfg[`CFG_ADDR_CLK_POL];
    wire clk_now = pin_q[2] ^ pol;
    wire clk_prev = clk_prev_ff ^ pol;
    wire lead_edge = clk_prev && !clk_now;
    wire trail_edge = !clk_prev && clk_now;
    wire lsb_first = active_cfg[`CFG_ADDR_BIT_ORDER];
    wire standalone = active_cfg[`CFG_ADDR_STANDALONE];
    wire lockout = active_cfg[`CFG_ADDR_LOCKOUT];

    // Completed bytes pass through the FIFO to the latch writer
    wire [7:0] cmd_next = {cmd_ff[6:0], data_q_ff};
    wire byte_done = (state_ff == ST_WRITE) && lead_edge &&
        (bit_cnt_ff == 3'h7);
    wire fifo_in_ready;
    wire fifo_valid;
    wire [7:0] fifo_cmd;
    wire [6:0] f_addr = fifo_cmd[6:0];
    wire f_dat = fifo_cmd[`CMD_DATA_BIT];

    word_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(3)
    ) u_cmd_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(byte_done),
        .in_ready(fifo_in_ready),
        .in_data(cmd_next),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_cmd)
    );

    // Serial front end
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_prev_ff <= 1'b1;
            strobe_prev_ff <= 1'b1;
            state_ff <= ST_IDLE;
            cmd_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
            rec_bit_ff <= 5'h00;
            tx_latch_ff <= 32'h00000000;
            byte_cnt_ff <= 2'h0;
            cur_byte_ff <= 8'h00;
            record_index <= 3'h0;
        end else begin
            clk_prev_ff <= pin_q[2];
            strobe_prev_ff <= strobe;
            if (cs_n) begin
                state_ff <= ST_IDLE;
                bit_cnt_ff <= 3'h0;
                rec_bit_ff <= 5'h00;
                byte_cnt_ff <= 2'h0;
                record_index <= 3'h0;
                if (strobe && !standalone && pin_q[2]) begin
                    tx_latch_ff <= result_record;
                end
                if (standalone && mode_group_a[`A_BIT_LATCH_REQ]) begin
                    tx_latch_ff <= result_record;
                end
            end else begin
                state_ff <= strobe ? ST_READ : ST_WRITE;
                if (strobe != strobe_prev_ff) begin
                    bit_cnt_ff <= 3'h0;
                    rec_bit_ff <= 5'h00;
                    byte_cnt_ff <= 2'h0;
                end
                if (state_ff == ST_WRITE && lead_edge) begin
                    cmd_ff <= cmd_next;
                    bit_cnt_ff <= bit_cnt_ff + 3'h1;
                end
                if (state_ff == ST_READ && trail_edge &&
                    record_index != 3'h7 || state_ff == ST_READ &&
                    trail_edge && rec_bit_ff != 5'h1f) begin
                    rec_bit_ff <= rec_bit_ff + 5'h01;
                    if (rec_bit_ff[2:0] == 3'h7) begin
                        byte_cnt_ff <= byte_cnt_ff + 2'h1;
                    end
                    if (rec_bit_ff == 5'h1f) begin
                        record_index <= record_index + 3'h1;
                    end
                end
            end
            case (byte_cnt_ff)
                2'h0: cur_byte_ff <= tx_latch_ff[7:0];
                2'h1: cur_byte_ff <= tx_latch_ff[15:8];
                2'h2: cur_byte_ff <= tx_latch_ff[23:16];
                default: cur_byte_ff <= tx_latch_ff[31:24];
            endcase
        end
    end

    // Latch writer
    // strobe from FIFO output
    wire wr_cfg = fifo_valid && (f_addr < `CFG_ADDR_LIMIT);
    wire wr_a = fifo_valid &&
        in_range(f_addr, `ADDR_GROUP_A_BASE, `ADDR_GROUP_A_LAST);
    wire wr_b = fifo_valid &&
        in_range(f_addr, `ADDR_GROUP_B_BASE, `ADDR_GROUP_B_LAST);
    wire precharge = fifo_valid && (f_addr == `ADDR_PRECHARGE);

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_group_a <= `RESET_MODE_A;
            mode_group_b <= `RESET_MODE_B;
            shadow_ff <= `RESET_CFG;
            group_pointer <= 3'h0;
            otp_write_pulse <= 1'b0;
            otp_write_addr <= 7'h00;
            otp_write_data <= 1'b0;
            active_cfg <= `RESET_CFG;
        end else begin
            otp_write_pulse <= 1'b0;
            if (wr_a) begin
                mode_group_a[f_addr[1:0]] <= f_dat;
            end
            if (wr_b && !lockout) begin
                mode_group_b[f_addr[2:0]] <= f_dat;
            end
            if (wr_cfg && !lockout) begin
                shadow_ff[f_addr] <= f_dat;
                if (mode_group_b[`B_BIT_WR_ENABLE]) begin
                    otp_write_pulse <= 1'b1;
                    otp_write_addr <= f_addr;
                    otp_write_data <= f_dat;
                end
            end
            if (precharge) begin
                group_pointer <= group_pointer + 3'h1;
            end
            active_cfg <= mode_group_b[`B_BIT_RD_DISABLE] ? shadow_ff :
                otp_cells;
        end
    end

    // Pin drivers
    wire [2:0] bit_sel = lsb_first ? rec_bit_ff[2:0] : ~rec_bit_ff[2:0];
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_data_line_out <= 1'b1;
            serial_data_line_oe <= 1'b0;
            direction_latch_strobe_out <= 1'b1;
            direction_latch_strobe_oe <= 1'b0;
            serial_bit_clock_out <= 1'b1;
            serial_bit_clock_oe <= 1'b0;
        end else begin
            if (cs_n && standalone) begin
                direction_latch_strobe_out <= meter_status[0];
                serial_bit_clock_out <= meter_status[1];
                serial_data_line_out <= meter_status[2];
                direction_latch_strobe_oe <= 1'b1;
                serial_bit_clock_oe <= 1'b1;
                serial_data_line_oe <= 1'b1;
            end else begin
                direction_latch_strobe_oe <= 1'b0;
                serial_bit_clock_oe <= 1'b0;
                serial_data_line_oe <= !cs_n && strobe;
                serial_data_line_out <= cur_byte_ff[bit_sel];
            end
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pump_cnt_ff <= 6'h00;
            pump_phase_ff <= 1'b0;
            motor_out_pos <= 1'b0;
            motor_out_neg <= 1'b0;
        end else begin
            if (pump_cnt_ff == `PUMP_DIV) begin
                pump_cnt_ff <= 6'h00;
                pump_phase_ff <= !pump_phase_ff;
            end else begin
                pump_cnt_ff <= pump_cnt_ff + 6'h01;
            end
            if (mode_group_b[`B_BIT_BOOST]) begin
                motor_out_pos <= pump_phase_ff;
                motor_out_neg <= !pump_phase_ff;
            end else begin
                motor_out_pos <= motor_drive_pos;
                motor_out_neg <= motor_drive_neg;
            end
        end
    end
endmodule // meter_serial_port

// file: testbench/meter_serial_port_properties.sv
// Pin-level checks for the serial port and its mode latches
`timescale 1ns/100ps
module meter_serial_port_properties (
    // Clock and reset
    input logic sys_clk,
    input logic rst_b,
    // Port pins
    input logic serial_chip_select,
    input logic direction_latch_strobe_in,
    input logic direction_latch_strobe_oe,
    input logic serial_bit_clock_oe,
    input logic serial_data_line_oe,
    // Configuration and latches
    input logic [111:0] otp_cells,
    input logic [111:0] active_cfg,
    input logic otp_write_pulse,
    input logic [6:0] otp_write_addr,
    input logic [3:0] mode_group_a,
    input logic [6:0] mode_group_b,
    input logic [2:0] group_pointer,
    // Motor path
    input logic motor_drive_pos,
    input logic motor_drive_neg,
    input logic motor_out_pos,
    input logic motor_out_neg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence read_held;
        (!serial_chip_select && direction_latch_strobe_in) [*6];
    endsequence
    sequence write_held;
        (!serial_chip_select && !direction_latch_strobe_in) [*6];
    endsequence
    sequence port_idle;
        (serial_chip_select && !active_cfg[3]) [*6];
    endsequence

    read_drive_a:
        assert property (read_held |-> serial_data_line_oe)
        else $error("data pin not driven in read mode");
    write_input_a:
        assert property (write_held |-> !serial_data_line_oe)
        else $error("data pin driven in write mode");
    idle_release_a:
        assert property (port_idle |-> !serial_data_line_oe &&
            !direction_latch_strobe_oe && !serial_bit_clock_oe)
        else $error("port pin driven while idle");
    standalone_drive_a:
        assert property ((serial_chip_select && active_cfg[3]) [*6] |->
            direction_latch_strobe_oe && serial_bit_clock_oe &&
            serial_data_line_oe)
        else $error("status not driven in standalone mode");
    cfg_source_a:
        assert property ((!mode_group_b[5] && $stable(otp_cells)) [*4] |->
            active_cfg == otp_cells)
        else $error("active config not taken from otp cells");
    otp_pulse_a:
        assert property (otp_write_pulse |-> mode_group_b[6] &&
            otp_write_addr < 7'h70 ##1 !otp_write_pulse)
        else $error("bad permanent write pulse");
    pump_off_a:
        assert property ((!mode_group_b[1] &&
            $stable({motor_drive_pos, motor_drive_neg})) [*3] |->
            motor_out_pos == motor_drive_pos &&
            motor_out_neg == motor_drive_neg)
        else $error("motor outputs do not follow drive inputs");
    lockout_hold_a:
        assert property (active_cfg[0] && $past(active_cfg[0]) |->
            $stable(mode_group_b))
        else $error("group b changed under lockout");
    pointer_step_a:
        assert property ($changed(group_pointer) |->
            group_pointer == $past(group_pointer) + 3'h1)
        else $error("group pointer moved by other than one");
    latch_quiet_a:
        assert property (serial_chip_select [*8] |=>
            $stable(mode_group_a) && $stable(mode_group_b))
        else $error("mode latch changed with select high");
endmodule // meter_serial_port_properties

bind meter_serial_port meter_serial_port_properties chk (.sys_clk, .rst_b,
    .serial_chip_select, .direction_latch_strobe_in,
    .direction_latch_strobe_oe, .serial_bit_clock_oe, .serial_data_line_oe,
    .otp_cells, .active_cfg, .otp_write_pulse, .otp_write_addr,
    .mode_group_a, .mode_group_b, .group_pointer, .motor_drive_pos,
    .motor_drive_neg, .motor_out_pos, .motor_out_neg);

// file: testbench/host_master.sv
// Host master model that drives the serial port lines
`timescale 1ns/100ps
module host_master (
    // Clock
    input wire logic sys_clk,
    // Lines driven by the host
    output logic serial_chip_select,
    output logic host_strobe,
    output logic host_clk,
    output logic host_data,
    output logic host_data_oe,
    // Resolved data pin
    input wire logic data_pin
);
    // Set while the clock polarity bit is 1
    logic clk_inv = 1'b0;

    initial begin
        serial_chip_select = 1'b1;
        host_strobe = 1'b1;
        host_clk = 1'b1;
        host_data = 1'b1;
        host_data_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic to_idle;
        serial_chip_select <= 1'b1;
        host_data_oe <= 1'b0;
        host_data <= 1'b1;
        tick(4);
        host_strobe <= 1'b1;
        tick(8);
    endtask

    // command byte msb first; fewer bits aborts it
    task automatic send_cmd(input logic [7:0] cmd, input int nbits);
        host_strobe <= 1'b0;
        tick(4);
        serial_chip_select <= 1'b0;
        host_data_oe <= 1'b1;
        tick(8);
        for (int i = 7; i > 7 - nbits; i--) begin
            host_clk <= !clk_inv;
            tick(2);
            host_data <= cmd[i];
            tick(2);
            host_clk <= clk_inv;
            tick(4);
        end
        host_clk <= 1'b1;
        tick(8);
        to_idle();
    endtask

    // one record: bytes low first, bits msb first
    task automatic read_rec(output logic [31:0] rec);
        tick(8);
        serial_chip_select <= 1'b0;
        tick(8);
        for (int i = 0; i < 32; i++) begin
            host_clk <= 1'b0;
            tick(7);
            rec[8 * (i / 8) + 7 - i % 8] = data_pin;
            tick(1);
            host_clk <= 1'b1;
            tick(4);
        end
        to_idle();
    endtask
endmodule // host_master

// file: testbench/meter_serial_port_bench.sv
// Self-checking bench for the serial port with mode latches
`timescale 1ns/100ps
module meter_serial_port_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] result_record = 32'h8c3a51e7;
    logic [2:0] meter_status = 3'h5;
    logic [111:0] otp_cells = {14{8'h40}};
    logic motor_drive_pos = 1'b0;
    logic motor_drive_neg = 1'b0;
    wire serial_chip_select, h_strobe, h_clk, h_data, h_data_oe;
    wire strobe_out, strobe_oe, clk_out, clk_oe, data_out, data_oe;
    wire strobe_pin, clk_pin, data_pin;
    wire [2:0] record_index, group_pointer;
    wire [111:0] active_cfg;
    wire otp_write_pulse, otp_write_data, motor_out_pos, motor_out_neg;
    wire [6:0] otp_write_addr, mode_group_b;
    wire [3:0] mode_group_a;
    logic [3:0] ea = 4'h0;
    logic [6:0] eb = 7'h0;
    logic [7:0] n_pulse = 8'h0;
    logic [7:0] pulse_info = 8'h0;
    logic [31:0] rec;
    logic [2:0] rec_last = 3'h0;
    logic prev;
    int n_mismatch = 0;
    int checks = 0;
    int toggles;

    always #12.5 sys_clk = ~sys_clk;
    assign strobe_pin = strobe_oe ? strobe_out : h_strobe;
    assign clk_pin = clk_oe ? clk_out : h_clk;
    assign data_pin = data_oe ? data_out : (h_data_oe ? h_data : 1'b1);

    host_master host (.sys_clk, .serial_chip_select, .host_strobe(h_strobe),
        .host_clk(h_clk), .host_data(h_data), .host_data_oe(h_data_oe),
        .data_pin);
    meter_serial_port dut (.sys_clk, .rst_b, .serial_chip_select,
        .direction_latch_strobe_in(strobe_pin),
        .direction_latch_strobe_out(strobe_out),
        .direction_latch_strobe_oe(strobe_oe),
        .serial_bit_clock_in(clk_pin), .serial_bit_clock_out(clk_out),
        .serial_bit_clock_oe(clk_oe), .serial_data_line_in(data_pin),
        .serial_data_line_out(data_out), .serial_data_line_oe(data_oe),
        .result_record, .meter_status, .record_index, .group_pointer,
        .otp_cells, .active_cfg, .otp_write_pulse, .otp_write_addr,
        .otp_write_data, .mode_group_a, .mode_group_b, .motor_out_pos,
        .motor_out_neg, .motor_drive_pos, .motor_drive_neg);

    always @(posedge sys_clk) begin
        if (record_index !== 3'h0)
            rec_last <= record_index;
        if (otp_write_pulse === 1'b1) begin
            n_pulse <= n_pulse + 8'h1;
            pulse_info <= {otp_write_addr, otp_write_data};
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #750000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        wait_clk(12);
        rst_b <= 1'b1;
        wait_clk(6);
        check({mode_group_a, mode_group_b}, 11'h0);
        check({strobe_oe, clk_oe, data_oe}, 3'h0);
        for (int d = 1; d >= 0; d--) begin
            for (int a = 7'h70; a < 7'h7f; a++) begin
                if (a < 7'h74 || a >= 7'h78) begin
                    host.send_cmd({d[0], a[6:0]}, 8);
                    if (a < 7'h74)
                        ea[a - 7'h70] = d[0];
                    else
                        eb[a - 7'h78] = d[0];
                    check({mode_group_a, mode_group_b}, {ea, eb});
                end
            end
        end
        check(group_pointer, 3'h0);
        host.send_cmd(8'h7f, 8);
        host.send_cmd(8'hff, 8);
        check({group_pointer, mode_group_a, mode_group_b}, 14'h1000);
        host.send_cmd(8'hf8, 4);
        check(mode_group_b, 7'h0);
        check(active_cfg, otp_cells);
        host.send_cmd(8'h85, 8);
        host.send_cmd(8'hfd, 8);
        check(active_cfg, 112'h20);
        host.send_cmd(8'hfe, 8);
        host.send_cmd(8'h06, 8);
        host.send_cmd(8'h7e, 8);
        check({n_pulse, pulse_info}, 16'h010c);
        motor_drive_pos <= 1'b1;
        wait_clk(4);
        check({motor_out_pos, motor_out_neg}, 2'h2);
        host.send_cmd(8'hf9, 8);
        toggles = 0;
        prev = motor_out_pos;
        for (int i = 0; i < 200; i++) begin
            wait_clk(1);
            if (motor_out_pos !== prev)
                toggles++;
            prev = motor_out_pos;
        end
        check(toggles == 5, 1'b1);
        host.send_cmd(8'h79, 8);
        host.read_rec(rec);
        check({rec_last, rec}, {3'h1, 32'h8c3a51e7});
        host.send_cmd(8'h82, 8);
        host.read_rec(rec);
        check(rec, 32'h315c8ae7);
        host.send_cmd(8'h02, 8);
        host.send_cmd(8'h83, 8);
        check({strobe_oe, clk_oe, data_oe, strobe_out, clk_out, data_out},
            6'h3d);
        host.send_cmd(8'h03, 8);
        check({strobe_oe, clk_oe, data_oe}, 3'h0);
        host.send_cmd(8'h81, 8);
        host.clk_inv <= 1'b1;
        host.send_cmd(8'hf2, 8);
        check(mode_group_a, 4'h4);
        host.send_cmd(8'h01, 8);
        host.clk_inv <= 1'b0;
        host.send_cmd(8'h80, 8);
        host.send_cmd(8'hf8, 8);
        host.send_cmd(8'hf1, 8);
        host.send_cmd(8'h7f, 8);
        check({mode_group_a, mode_group_b, group_pointer}, 14'h1903);
        rst_b <= 1'b0;
        wait_clk(2);
        rst_b <= 1'b1;
        wait_clk(6);
        check({mode_group_a, mode_group_b, group_pointer}, 14'h0);
        tally_and_finish();
    end
endmodule // meter_serial_port_bench
